//--- hdl/codec_frame_pkg.sv
// Package with register map, field layout and reset values of the frame config
package codec_frame_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam logic [ADDR_W-1:0] FRAME_CONFIG_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] FRAME_STATUS_ADDR = 4'h4;
	localparam int DEPTH_LSB = 10;
	localparam int DEPTH_W = 2;
	localparam int FLEN_LSB = 5;
	localparam int FLEN_W = 4;
	localparam int WSIZE_LSB = 0;
	localparam int WSIZE_W = 4;
	localparam logic [REG_W-1:0] CONFIG_WMASK = 16'h0DEF;
	localparam logic [REG_W-1:0] CONFIG_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;
endpackage : codec_frame_pkg

//--- hdl/word_tally.sv
// Counter that wraps after a programmed number of steps
`timescale 1ns/1ps
module word_tally #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Step control
	input wire logic step_i,
	input wire logic [W-1:0] last_i,
	// Count state
	output logic [W-1:0] count_o,
	output logic wrap_o
);
	// A tally needs at least one bit to count
	if (W < 1)
	begin : g_bad_w
		$error("word_tally needs W of at least 1");
	end
	wire logic at_last;
	assign at_last = (count_o >= last_i);
	assign wrap_o = step_i && at_last;
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			count_o <= '0;
		else if (wrap_o)
			count_o <= '0;
		else if (step_i)
			count_o <= count_o + 1'b1;
	end
endmodule : word_tally

//--- hdl/codec_frame_config.sv
// Frame configuration register of the codec serial interface, with frame tally
// How it works
// - Buffer depth field at bits 11:10 gives field plus one words per interrupt.
// - Frame length field at bits 8:5 gives field plus one words per frame.
// - Word size field at bits 3:0 gives field plus one bits per word.
// - Bits 15:12, 9 and 4 ignore writes and read as zero.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module codec_frame_config (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Avalon-MM slave
	input wire logic [codec_frame_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [codec_frame_pkg::DATA_W-1:0] avs_writedata_i,
	output logic [codec_frame_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Shift engine word strobe
	input wire logic word_done_i,
	// Configuration toward the shift engine
	output logic [4:0] word_bits_o,
	output logic [4:0] frame_words_o,
	output logic [2:0] buffer_words_o,
	output logic frame_start_o,
	output logic buffer_full_o
);
	logic [codec_frame_pkg::REG_W-1:0] cfg;
	logic ack;
	wire logic req;
	wire logic sel_cfg;
	wire logic sel_stat;
	wire logic do_write;
	wire logic [codec_frame_pkg::REG_W-1:0] byte_mask;
	wire logic [codec_frame_pkg::REG_W-1:0] next_cfg;
	wire logic [codec_frame_pkg::DATA_W-1:0] next_readdata;
	wire logic [codec_frame_pkg::DEPTH_W-1:0] depth_sel;
	wire logic [codec_frame_pkg::FLEN_W-1:0] frame_len_sel;
	wire logic [codec_frame_pkg::WSIZE_W-1:0] word_size_sel;
	wire logic [codec_frame_pkg::FLEN_W-1:0] word_idx;
	wire logic [codec_frame_pkg::DEPTH_W-1:0] buf_idx;
	wire logic frame_wrap;
	wire logic buf_wrap;

	// One wait cycle per access keeps read data registered
	assign req = (avs_read_i || avs_write_i) && !ack;
	assign sel_cfg = (avs_address_i == codec_frame_pkg::FRAME_CONFIG_ADDR);
	assign sel_stat = (avs_address_i == codec_frame_pkg::FRAME_STATUS_ADDR);
	assign do_write = req && avs_write_i && sel_cfg;
	assign byte_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	// Unimplemented bits never store
	assign next_cfg = (cfg & ~(byte_mask & codec_frame_pkg::CONFIG_WMASK))
		| (avs_writedata_i[15:0] & byte_mask
		& codec_frame_pkg::CONFIG_WMASK);
	assign next_readdata = sel_cfg ? {16'h0000, cfg}
		: sel_stat ? {24'h000000, word_idx, 2'h0, buf_idx}
		: codec_frame_pkg::UNMAPPED_READ;

	assign depth_sel =
		cfg[codec_frame_pkg::DEPTH_LSB +: codec_frame_pkg::DEPTH_W];
	assign frame_len_sel =
		cfg[codec_frame_pkg::FLEN_LSB +: codec_frame_pkg::FLEN_W];
	assign word_size_sel =
		cfg[codec_frame_pkg::WSIZE_LSB +: codec_frame_pkg::WSIZE_W];

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			cfg <= codec_frame_pkg::CONFIG_RESET;
			ack <= 1'b0;
			avs_readdata_o <= codec_frame_pkg::UNMAPPED_READ;
		end
		else
		begin
			ack <= req;
			if (do_write)
				cfg <= next_cfg;
			if (req && avs_read_i)
				avs_readdata_o <= next_readdata;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= !req;
	end

	// Word and buffer tallies; a frame length written at or below the current word index wraps on the next finished word
	word_tally #(.W(codec_frame_pkg::FLEN_W)) u_frame_tally (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.step_i(word_done_i),
		.last_i(frame_len_sel),
		.count_o(word_idx),
		.wrap_o(frame_wrap)
	);
	word_tally #(.W(codec_frame_pkg::DEPTH_W)) u_buf_tally (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.step_i(word_done_i),
		.last_i(depth_sel),
		.count_o(buf_idx),
		.wrap_o(buf_wrap)
	);

	// Word sizes 1..3 bits are illegal; the engine gets them unchecked
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			word_bits_o <= 5'h01;
			frame_words_o <= 5'h01;
			buffer_words_o <= 3'h1;
			frame_start_o <= 1'b0;
			buffer_full_o <= 1'b0;
		end
		else
		begin
			word_bits_o <= {1'b0, word_size_sel} + 5'h01;
			frame_words_o <= {1'b0, frame_len_sel} + 5'h01;
			buffer_words_o <= {1'b0, depth_sel} + 3'h1;
			frame_start_o <= frame_wrap;
			buffer_full_o <= buf_wrap;
		end
	end

	property p_reserved_zero;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(cfg & ~codec_frame_pkg::CONFIG_WMASK) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved config bit set");

	property p_hold;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!do_write |=> $stable(cfg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("config changed without write");

	property p_write;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		do_write && (avs_byteenable_i[1:0] == 2'h3) |=>
		cfg == ($past(avs_writedata_i[15:0]) & codec_frame_pkg::CONFIG_WMASK);
	endproperty
	a_write: assert property (p_write)
		else $error("config write not stored");

	property p_bits;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$stable(cfg) |=> word_bits_o == {1'b0, $past(word_size_sel)} + 5'h01;
	endproperty
	a_bits: assert property (p_bits)
		else $error("word size output wrong");

	property p_words;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$stable(cfg) |=> frame_words_o == {1'b0, $past(frame_len_sel)} + 5'h01;
	endproperty
	a_words: assert property (p_words)
		else $error("frame length output wrong");

	property p_depth;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$stable(cfg) |=> buffer_words_o == {1'b0, $past(depth_sel)} + 3'h1;
	endproperty
	a_depth: assert property (p_depth)
		else $error("buffer depth output wrong");

	property p_frame_start;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		word_done_i && word_idx == frame_len_sel |=>
		frame_start_o && word_idx == 4'h0;
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("frame did not restart");

	property p_buf_full;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		word_done_i && buf_idx == depth_sel |=> buffer_full_o;
	endproperty
	a_buf_full: assert property (p_buf_full)
		else $error("buffer full missed");

	property p_wait;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait)
		else $error("bus access not answered");

	property p_wait_once;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_once: assert property (p_wait_once)
		else $error("access answered twice");

	property p_read_reserved;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		req && avs_read_i && sel_cfg |=>
		(avs_readdata_o & ~{16'h0000, codec_frame_pkg::CONFIG_WMASK}) == 32'h0;
	endproperty
	a_read_reserved: assert property (p_read_reserved)
		else $error("reserved bit read as one");

	// Tallies move only on a finished word, never on a register access
	property p_tally_hold;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!word_done_i |=> $stable(word_idx) && $stable(buf_idx);
	endproperty
	a_tally_hold: assert property (p_tally_hold)
		else $error("word tally moved without a word");

	property p_cov_write;
		@(posedge core_clk_i) disable iff (sys_rst_i) do_write;
	endproperty
	c_write: cover property (p_cov_write);
	property p_cov_frame;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		frame_start_o && frame_words_o == 5'h10;
	endproperty
	c_frame: cover property (p_cov_frame);
	property p_cov_buf;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		buffer_full_o && buffer_words_o == 3'h4;
	endproperty
	c_buf: cover property (p_cov_buf);
	property p_cov_status;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		req && avs_read_i && sel_stat;
	endproperty
	c_status: cover property (p_cov_status);
endmodule : codec_frame_config

//--- tb/word_source.sv
// Codec side model that finishes serial words on request
`timescale 1ns/1ps
module word_source (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Request: word count and idle cycles between words
	input wire logic load_i,
	input wire logic [7:0] words_i,
	input wire logic [3:0] gap_i,
	// Word strobe
	output logic word_done_o
);
	logic [7:0] left;
	logic [3:0] idle;
	// Gap 0 gives back-to-back words, the hardest case for the tally
	always_ff @(posedge core_clk_i)
	begin
		word_done_o <= 1'b0;
		if (sys_rst_i)
			left <= 8'h00;
		else if (load_i)
		begin
			left <= words_i;
			idle <= gap_i;
		end
		else if (left != 8'h00)
		begin
			if (idle != 4'h0)
				idle <= idle - 4'h1;
			else
			begin
				word_done_o <= 1'b1;
				left <= left - 8'h01;
				idle <= gap_i;
			end
		end
	end
endmodule : word_source

//--- tb/tb_top.sv
// Self-checking bench for the frame configuration register
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] be = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [31:0] got;
	logic wreq, done, fs, bf;
	logic load = 1'b0;
	logic [7:0] nw = 8'h00;
	logic [3:0] gap = 4'h0;
	logic [4:0] wbits, fwords;
	logic [2:0] bwords;
	int n_errors = 0;
	int n_compared = 0;
	int nf = 0;
	int nb = 0;
	int nd = 0;
	// Rows: byte enables, write data, expected readback
	logic [35:0] rows [5] = '{{4'h3, 16'hFFFF, 16'h0DEF},
		{4'h3, 16'h0003, 16'h0003}, {4'h3, 16'h0C25, 16'h0C25},
		{4'h1, 16'hFFFF, 16'h0CEF}, {4'h2, 16'h1200, 16'h00EF}};
	codec_frame_config i_codec_frame_config (.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.word_done_i(done), .word_bits_o(wbits), .frame_words_o(fwords),
		.buffer_words_o(bwords), .frame_start_o(fs), .buffer_full_o(bf));
	word_source i_word_source (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.load_i(load), .words_i(nw), .gap_i(gap), .word_done_o(done));
	initial
	begin
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		nf += (fs === 1'b1);
		nb += (bf === 1'b1);
		nd += (done === 1'b1);
	end
	task automatic print_verdict();
	begin
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask : print_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
	begin
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	end
	endtask : chk
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] b,
		input logic [31:0] d);
		int i;
	begin
		@(posedge core_clk_i);
		adr <= a;
		be <= b;
		wd <= d;
		wr <= w;
		rd <= !w;
		for (i = 0; i < 20; i++)
		begin
			@(posedge core_clk_i);
			if (wreq === 1'b0)
				break;
		end
		// Read data is taken at the edge that sees waitrequest low
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (i == 20)
		begin
			n_errors++;
			print_verdict();
		end
	end
	endtask : bus
	task automatic reset_chk(input int n);
	begin
		sys_rst_i <= 1'b1;
		repeat (n) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		bus(1'b0, codec_frame_pkg::FRAME_CONFIG_ADDR, 4'hF, 32'h0);
		chk(got, 32'h0);
		chk({wbits, fwords, bwords}, {5'h01, 5'h01, 3'h1});
		bus(1'b0, codec_frame_pkg::FRAME_STATUS_ADDR, 4'hF, 32'h0);
		chk(got, 32'h0);
	end
	endtask : reset_chk
	// Word size never below 3 here; those settings are software faults
	task automatic frames(input logic [3:0] g, input logic [7:0] n,
		input int ef, input int eb);
		int i;
		int target;
	begin
		target = nd + int'(n);
		@(posedge core_clk_i);
		load <= 1'b1;
		nw <= n;
		gap <= g;
		@(posedge core_clk_i);
		load <= 1'b0;
		// Counts settle by the falling edge, so no race with the counters
		for (i = 0; i < 200 && nd < target; i++)
			@(negedge core_clk_i);
		if (i == 200)
		begin
			n_errors++;
			print_verdict();
		end
		repeat (3) @(negedge core_clk_i);
		chk(nf, ef);
		chk(nb, eb);
	end
	endtask : frames
	initial
	begin
		#40000;
		n_errors++;
		print_verdict();
	end
	initial
	begin
		reset_chk(12);
		foreach (rows[k])
		begin
			bus(1'b1, 4'h0, rows[k][35:32], {16'hFFFF, rows[k][31:16]});
			bus(1'b0, 4'h0, 4'hF, 32'h0);
			chk(got, {16'h0, rows[k][15:0]});
			chk(wbits, 5'(rows[k][3:0]) + 5'h01);
			chk(fwords, 5'(rows[k][8:5]) + 5'h01);
			chk(bwords, 3'(rows[k][11:10]) + 3'h1);
		end
		bus(1'b1, 4'h8, 4'hF, 32'hFFFF);
		bus(1'b0, 4'h0, 4'hF, 32'h0);
		chk(got, 32'h00EF);
		bus(1'b0, 4'h8, 4'hF, 32'h0);
		chk(got, codec_frame_pkg::UNMAPPED_READ);
		bus(1'b1, 4'h0, 4'h3, 32'h0443);
		frames(4'h0, 8'h06, 2, 3);
		frames(4'h3, 8'h06, 4, 6);
		// A part frame leaves word index 2 and buffer index 1
		frames(4'h0, 8'h05, 5, 8);
		bus(1'b1, codec_frame_pkg::FRAME_STATUS_ADDR, 4'hF, 32'hFFFF);
		bus(1'b0, codec_frame_pkg::FRAME_STATUS_ADDR, 4'hF, 32'h0);
		chk(got, 32'h00000021);
		bus(1'b0, codec_frame_pkg::FRAME_CONFIG_ADDR, 4'hF, 32'h0);
		chk(got, 32'h00000443);
		reset_chk(2);
		print_verdict();
	end
endmodule : tb_top
